// file: src/adcms_device.sv
`timescale 1ns/1ps
`default_nettype none
module adcms_device (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  adcms_cfg_if.dev         cfg,
  output logic             powered_down_o,
  output logic             single_mode_o,
  output logic [1:0]       clk_div_code_o,
  output logic             sample_tick_o,
  output logic             resync_o,
  output logic [1:0]       route_first_o,
  output logic [1:0]       route_second_o,
  output logic [15:0]      bit_clk_phase_o,
  output logic [1:0]       cm_buffer_drive_o,
  output logic             cfg_write_o
);

  function automatic logic [1:0] xsel_src(input logic [7:0] code);
    case (code)
      adcms_pkg::XSEL_IN1[7:0],
      adcms_pkg::XSEL_DUAL_A[7:0]:     xsel_src = adcms_pkg::SRC_IN1;
      adcms_pkg::XSEL_IN2_SINGLE[7:0],
      adcms_pkg::XSEL_DUAL_B[7:0]:     xsel_src = adcms_pkg::SRC_IN2;
      default:                         xsel_src = adcms_pkg::SRC_NONE;
    endcase
  endfunction

  logic [4:0]  pin_s1_r;
  logic [4:0]  pin_s2_r;
  logic [1:0]  pin_s3_r;
  logic        rst_n_s;
  logic        cs_n_s;
  logic        pd_s;
  logic        sclk_s;
  logic        sdata_s;
  logic        sclk_rise;
  logic        cs_rise;
  logic        cs_fall;
  logic [23:0] shift_r;
  logic [4:0]  bits_r;
  logic        wr;
  logic [7:0]  wr_addr;
  logic [15:0] wr_data;
  logic        soft_rst_r;
  logic        chip_rst;
  logic [15:0] power_r;
  logic [15:0] mode_r;
  logic [15:0] xsel_a_r;
  logic [15:0] xsel_b_r;
  logic [15:0] phase_r;
  logic [1:0]  cmbuf_r;
  logic        pd_now;
  logic [2:0]  tick_cnt_r;
  logic [2:0]  tick_last;

  // pins come from another chip, so two flops before any use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= adcms_pkg::PIN_SYNC_RST;
      pin_s2_r <= adcms_pkg::PIN_SYNC_RST;
      pin_s3_r <= 2'h1;
    end else begin
      pin_s1_r <= {cfg.sdata, cfg.sclk, cfg.power_down_pin,
                   cfg.cs_n, cfg.active_low_reset_pin_n};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= {pin_s2_r[3], pin_s2_r[1]};
    end
  end

  assign rst_n_s   = pin_s2_r[0];
  assign cs_n_s    = pin_s2_r[1];
  assign pd_s      = pin_s2_r[2];
  assign sclk_s    = pin_s2_r[3];
  assign sdata_s   = pin_s2_r[4];
  // only the rising edge of the serial clock is used
  assign sclk_rise = sclk_s & ~pin_s3_r[1];
  assign cs_rise   = cs_n_s & ~pin_s3_r[0];
  assign cs_fall   = ~cs_n_s & pin_s3_r[0];

  localparam logic [4:0] FRAME_LIM = adcms_pkg::FRAME_BITS;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_r <= 24'h000000;
      bits_r  <= 5'h00;
    end else if (cs_fall) begin
      bits_r <= 5'h00;
    end else if (!cs_n_s && sclk_rise && bits_r <= FRAME_LIM) begin
      shift_r <= {shift_r[22:0], sdata_s};
      bits_r  <= bits_r + 5'h01;
    end
  end

  // short or long frames are dropped whole
  assign wr      = cs_rise && (bits_r == adcms_pkg::FRAME_BITS);
  assign wr_addr = shift_r[23:16];
  assign wr_data = shift_r[15:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= wr && wr_addr == adcms_pkg::ADDR_SOFT_RESET
                    && wr_data[adcms_pkg::SOFT_RESET_BIT];
    end
  end

  assign chip_rst = rst_i | ~rst_n_s | soft_rst_r;

  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      cfg_write_o <= 1'b0;
    end else begin
      cfg_write_o <= wr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      power_r <= adcms_pkg::POWER_RST;
    end else if (wr && wr_addr == adcms_pkg::ADDR_POWER) begin
      power_r <= wr_data;
    end
  end

  // stored at any time, applied only when power down is left
  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      mode_r <= adcms_pkg::MODE_RST;
    end else if (wr && wr_addr == adcms_pkg::ADDR_MODE) begin
      mode_r <= wr_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      xsel_a_r <= adcms_pkg::XSEL_RST;
      xsel_b_r <= adcms_pkg::XSEL_RST;
    end else if (wr) begin
      if (wr_addr == adcms_pkg::ADDR_XSEL_A) begin
        xsel_a_r <= wr_data;
      end
      if (wr_addr == adcms_pkg::ADDR_XSEL_B) begin
        xsel_b_r <= wr_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      phase_r <= adcms_pkg::PHASE_RST;
    end else if (wr && wr_addr == adcms_pkg::ADDR_PHASE) begin
      phase_r <= wr_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      cmbuf_r <= adcms_pkg::CMBUF_RST;
    end else if (wr && wr_addr == adcms_pkg::ADDR_CMBUF) begin
      cmbuf_r <= wr_data[1:0];
    end
  end

  assign pd_now = pd_s | power_r[adcms_pkg::PD_BIT];

  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      powered_down_o <= 1'b0;
    end else begin
      powered_down_o <= pd_now;
    end
  end

  // mode and divider switch only on the way out of power down,
  // where the internal resync can run without live samples
  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      single_mode_o  <= 1'b1;
      clk_div_code_o <= 2'h0;
      resync_o       <= 1'b0;
    end else if (powered_down_o && !pd_now) begin
      single_mode_o  <= mode_r[adcms_pkg::CH_MODE_LSB +: 3]
                        == adcms_pkg::CH_SINGLE;
      clk_div_code_o <= mode_r[adcms_pkg::DIV_LSB +: 2];
      resync_o       <= 1'b1;
    end else begin
      resync_o <= 1'b0;
    end
  end

  assign tick_last = 3'((4'h1 << clk_div_code_o) - 4'h1);

  // ticks advance on rising edges only
  always_ff @(posedge clk_i) begin
    if (chip_rst || powered_down_o) begin
      tick_cnt_r    <= 3'h0;
      sample_tick_o <= 1'b0;
    end else if (tick_cnt_r >= tick_last) begin
      tick_cnt_r    <= 3'h0;
      sample_tick_o <= 1'b1;
    end else begin
      tick_cnt_r    <= tick_cnt_r + 3'h1;
      sample_tick_o <= 1'b0;
    end
  end

  // in single mode the second register is ignored and the second route is held at none
  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      route_first_o  <= adcms_pkg::SRC_IN1;
      route_second_o <= adcms_pkg::SRC_NONE;
    end else begin
      route_first_o  <= xsel_src(xsel_a_r[7:0]);
      route_second_o <= single_mode_o ? adcms_pkg::SRC_NONE
                        : xsel_src(xsel_b_r[7:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (chip_rst) begin
      bit_clk_phase_o   <= adcms_pkg::PHASE_RST;
      cm_buffer_drive_o <= adcms_pkg::CMBUF_RST;
    end else begin
      bit_clk_phase_o   <= phase_r;
      cm_buffer_drive_o <= cmbuf_r;
    end
  end

endmodule
`default_nettype wire

// file: include/adcms_pkg.sv
// Notes on behaviour
// - converter times everything from rising clock edge
// - host resets converter by pin or write
// - power down by pin or register write
// - phase register set only during power down; device takes and applies phase writes in any state
// - 0x0102 to 0x31 selects dual, divide two
// - 0x0001 to 0x31 selects single, divide one
// - pin low or 0x0000 restores active
// - host powers down around every mode change
// - host selects inputs after mode is active
// - input selection applies when write completes
// - crosspoint codes map inputs to channels
// - two-bit field controls common mode buffer
package adcms_pkg;
  localparam int CLK_NS      = 50;
  localparam int SPI_HALF_NS = 200;
  localparam logic [3:0] SPI_HALF_CYC =
    4'((SPI_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] FRAME_BITS = 5'd24;

  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_POWER      = 8'h0f;
  localparam logic [7:0] ADDR_MODE       = 8'h31;
  localparam logic [7:0] ADDR_XSEL_A     = 8'h3a;
  localparam logic [7:0] ADDR_XSEL_B     = 8'h3b;
  localparam logic [7:0] ADDR_PHASE      = 8'h42;
  localparam logic [7:0] ADDR_CMBUF      = 8'h50;

  localparam logic [15:0] SOFT_RESET_CMD   = 16'h0001;
  localparam logic [15:0] POWER_DOWN_CMD   = 16'h0200;
  localparam logic [15:0] POWER_UP_CMD     = 16'h0000;
  localparam logic [15:0] MODE_DUAL_DIV2   = 16'h0102;
  localparam logic [15:0] MODE_SINGLE_DIV1 = 16'h0001;
  localparam logic [15:0] XSEL_IN1         = 16'h0202;
  localparam logic [15:0] XSEL_IN2_SINGLE  = 16'h1010;
  localparam logic [15:0] XSEL_DUAL_A      = 16'h0404;
  localparam logic [15:0] XSEL_DUAL_B      = 16'h0808;

  localparam int SOFT_RESET_BIT = 0;
  localparam int PD_BIT         = 9;
  localparam int CH_MODE_LSB    = 0;
  localparam int DIV_LSB        = 8;
  localparam logic [2:0] CH_SINGLE = 3'h1;
  localparam logic [2:0] CH_DUAL   = 3'h2;

  localparam logic [15:0] POWER_RST = 16'h0000;
  localparam logic [15:0] MODE_RST  = 16'h0001;
  localparam logic [15:0] XSEL_RST  = 16'h0202;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [1:0]  CMBUF_RST = 2'h1;
  // pin order {sdata, sclk, pd, cs_n, reset_n}
  localparam logic [4:0]  PIN_SYNC_RST = 5'h03;

  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_IN1  = 2'h1;
  localparam logic [1:0] SRC_IN2  = 2'h2;

  localparam logic [3:0] HADDR_TX     = 4'h0;
  localparam logic [3:0] HADDR_PINS   = 4'h1;
  localparam logic [3:0] HADDR_SEQ    = 4'h2;
  localparam logic [3:0] HADDR_STATUS = 4'h3;
  localparam int PINS_RESET   = 0;
  localparam int PINS_PD      = 1;
  localparam int SEQ_SINGLE   = 0;
  localparam int SEQ_IN2      = 1;
  localparam int SEQ_RESET    = 2;
  localparam int SEQ_PHASE    = 3;
  localparam int SEQ_PHASE_LSB = 16;
  localparam int STATUS_BUSY  = 0;
  localparam int STATUS_SEQ   = 1;
  localparam logic [2:0] SEQ_LAST = 3'h6;

  typedef enum logic [1:0] {
    HF_IDLE  = 2'b00,
    HF_SHIFT = 2'b01,
    HF_END   = 2'b11
  } adcms_frame_t;
endpackage

// file: include/adcms_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcms_cfg_if;
  logic sclk;
  logic cs_n;
  logic sdata;
  logic active_low_reset_pin_n;
  logic power_down_pin;
  modport host (
    output sclk,
    output cs_n,
    output sdata,
    output active_low_reset_pin_n,
    output power_down_pin
  );
  modport dev (
    input sclk,
    input cs_n,
    input sdata,
    input active_low_reset_pin_n,
    input power_down_pin
  );
endinterface
`default_nettype wire

// file: src/adcms_host.sv
`timescale 1ns/1ps
`default_nettype none
module adcms_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  adcms_cfg_if.host        cfg,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             busy_o
);

  adcms_pkg::adcms_frame_t fstate_r;
  logic [3:0]  ph_r;
  logic [4:0]  bit_r;
  logic [23:0] sh_r;
  logic [23:0] tx_r;
  logic        tx_pend_r;
  logic [1:0]  pins_r;
  logic [31:0] seq_r;
  logic        seq_run_r;
  logic [2:0]  step_r;
  logic        step_skip;
  logic [23:0] step_word;
  logic        go;
  logic [23:0] go_word;
  logic        idle;

  // one entry of the setup sequence: reset, power down, phase,
  // mode, active, then both crosspoint registers
  always_comb begin
    step_skip = 1'b0;
    step_word = 24'h000000;
    case (step_r)
      3'h0: begin
        step_word = {adcms_pkg::ADDR_SOFT_RESET,
                     adcms_pkg::SOFT_RESET_CMD};
        step_skip = !seq_r[adcms_pkg::SEQ_RESET];
      end
      3'h1: step_word = {adcms_pkg::ADDR_POWER,
                         adcms_pkg::POWER_DOWN_CMD};
      3'h2: begin
        step_word = {adcms_pkg::ADDR_PHASE,
                     seq_r[adcms_pkg::SEQ_PHASE_LSB +: 16]};
        step_skip = !seq_r[adcms_pkg::SEQ_PHASE];
      end
      3'h3: step_word = {adcms_pkg::ADDR_MODE,
                         seq_r[adcms_pkg::SEQ_SINGLE]
                         ? adcms_pkg::MODE_SINGLE_DIV1
                         : adcms_pkg::MODE_DUAL_DIV2};
      3'h4: step_word = {adcms_pkg::ADDR_POWER,
                         adcms_pkg::POWER_UP_CMD};
      3'h5: step_word = {adcms_pkg::ADDR_XSEL_A,
                         !seq_r[adcms_pkg::SEQ_SINGLE]
                         ? adcms_pkg::XSEL_DUAL_A
                         : seq_r[adcms_pkg::SEQ_IN2]
                         ? adcms_pkg::XSEL_IN2_SINGLE
                         : adcms_pkg::XSEL_IN1};
      3'h6: step_word = {adcms_pkg::ADDR_XSEL_B,
                         !seq_r[adcms_pkg::SEQ_SINGLE]
                         ? adcms_pkg::XSEL_DUAL_B
                         : seq_r[adcms_pkg::SEQ_IN2]
                         ? adcms_pkg::XSEL_IN2_SINGLE
                         : adcms_pkg::XSEL_IN1};
      default: step_skip = 1'b1;
    endcase
  end

  assign idle    = fstate_r == adcms_pkg::HF_IDLE;
  assign go      = idle && ((seq_run_r && !step_skip) || tx_pend_r);
  assign go_word = seq_run_r ? step_word : tx_r;
  assign busy_o  = !idle || tx_pend_r || seq_run_r;

  // the sequencer waits for each frame to finish before the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_r     <= 32'h00000000;
      seq_run_r <= 1'b0;
      step_r    <= 3'h0;
    end else if (!seq_run_r) begin
      if (wr_i && addr_i == adcms_pkg::HADDR_SEQ && !busy_o) begin
        seq_r     <= wdata_i;
        seq_run_r <= 1'b1;
        step_r    <= 3'h0;
      end
    end else if (idle && (step_skip || go)) begin
      step_r <= step_r + 3'h1;
      if (step_r == adcms_pkg::SEQ_LAST) begin
        seq_run_r <= 1'b0;
      end
    end
  end

  // writes while busy are dropped, status shows why
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_r      <= 24'h000000;
      tx_pend_r <= 1'b0;
    end else if (wr_i && addr_i == adcms_pkg::HADDR_TX && !busy_o) begin
      tx_r      <= wdata_i[23:0];
      tx_pend_r <= 1'b1;
    end else if (go && !seq_run_r) begin
      tx_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_r <= 2'h0;
    end else if (wr_i && addr_i == adcms_pkg::HADDR_PINS) begin
      pins_r <= wdata_i[1:0];
    end
  end

  assign cfg.active_low_reset_pin_n = !pins_r[adcms_pkg::PINS_RESET];
  assign cfg.power_down_pin         = pins_r[adcms_pkg::PINS_PD];

  // msb first, data changes on the falling edge of sclk
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fstate_r  <= adcms_pkg::HF_IDLE;
      ph_r      <= 4'h0;
      bit_r     <= 5'h00;
      sh_r      <= 24'h000000;
      cfg.sclk  <= 1'b0;
      cfg.cs_n  <= 1'b1;
      cfg.sdata <= 1'b0;
    end else begin
      case (fstate_r)
        adcms_pkg::HF_IDLE: begin
          cfg.cs_n <= 1'b1;
          ph_r     <= 4'h0;
          bit_r    <= 5'h00;
          if (go) begin
            sh_r      <= {go_word[22:0], 1'b0};
            cfg.sdata <= go_word[23];
            cfg.cs_n  <= 1'b0;
            fstate_r  <= adcms_pkg::HF_SHIFT;
          end
        end
        adcms_pkg::HF_SHIFT: begin
          if (ph_r == adcms_pkg::SPI_HALF_CYC - 4'h1) begin
            cfg.sclk <= 1'b1;
            ph_r     <= ph_r + 4'h1;
          end else if (ph_r == 4'((adcms_pkg::SPI_HALF_CYC << 1) - 4'h1)) begin
            cfg.sclk <= 1'b0;
            ph_r     <= 4'h0;
            if (bit_r == adcms_pkg::FRAME_BITS - 5'h01) begin
              fstate_r <= adcms_pkg::HF_END;
            end else begin
              bit_r     <= bit_r + 5'h01;
              cfg.sdata <= sh_r[23];
              sh_r      <= {sh_r[22:0], 1'b0};
            end
          end else begin
            ph_r <= ph_r + 4'h1;
          end
        end
        adcms_pkg::HF_END: begin
          // hold cs low one half period, then high another
          ph_r <= ph_r + 4'h1;
          if (ph_r == adcms_pkg::SPI_HALF_CYC - 4'h1) begin
            cfg.cs_n <= 1'b1;
          end else if (ph_r == 4'((adcms_pkg::SPI_HALF_CYC << 1) - 4'h1)) begin
            fstate_r <= adcms_pkg::HF_IDLE;
          end
        end
        default: fstate_r <= adcms_pkg::HF_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        adcms_pkg::HADDR_TX:     rdata_o <= {8'h00, tx_r};
        adcms_pkg::HADDR_PINS:   rdata_o <= {30'h00000000, pins_r};
        adcms_pkg::HADDR_SEQ:    rdata_o <= seq_r;
        adcms_pkg::HADDR_STATUS: rdata_o <= {25'h0000000, step_r,
                                             2'h0, seq_run_r, busy_o};
        default:                 rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// file: testbench/adcms_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none
module adcms_cfg_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdata,
  input wire logic active_low_reset_pin_n,
  input wire logic power_down_pin
);
  logic       sclk_q_r;
  logic [4:0] bit_cnt_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) sclk_q_r <= 1'b0;
    else sclk_q_r <= sclk;
  end

  // counts serial bits of the open frame, cleared while deselected
  always_ff @(posedge clk_i) begin
    if (rst_i || cs_n) bit_cnt_r <= 5'h00;
    else if (sclk && !sclk_q_r) bit_cnt_r <= bit_cnt_r + 5'h01;
  end

  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_sclk_high_half: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  a_sclk_low_half: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase shorter than four cycles");
  a_data_held_high: assert property (sclk |-> $stable(sdata))
    else $error("serial data moved while clock high");
  a_frame_bit_count: assert property (
    $rose(cs_n) |-> bit_cnt_r == adcms_pkg::FRAME_BITS)
    else $error("frame closed with wrong bit count");
  a_frame_gap_min: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("frames closer than four cycles");
  a_frame_lead_in: assert property (
    $fell(cs_n) |-> !sclk [*4] ##1 sclk)
    else $error("first serial clock edge misplaced");
  a_pins_reset_idle: assert property (disable iff (1'b0)
    rst_i |=> active_low_reset_pin_n && !power_down_pin && cs_n)
    else $error("control pins not idle after reset");

  c_frame_done: cover property ($rose(cs_n));
  c_pd_pin: cover property ($rose(power_down_pin));
  c_reset_pin: cover property ($fell(active_low_reset_pin_n));
endmodule
`default_nettype wire

// file: testbench/adc_mode_setup_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_mode_setup_sequencer_tb;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic [3:0]  addr_i  = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i    = 1'b0;
  logic        rd_i    = 1'b0;
  logic [31:0] rdata_o;
  logic        busy_o;
  logic        pd_o;
  logic        single_o;
  logic        tick_o;
  logic [1:0]  div_o;
  logic [1:0]  first_o;
  logic [1:0]  second_o;
  logic [1:0]  cm_o;
  logic [15:0] phase_o;
  logic        resync_o;
  logic        cfg_write_o;
  int          resyncs    = 0;
  int          cfg_writes = 0;
  int          errors   = 0;
  int          compares = 0;
  int          cycles   = 0;

  adcms_cfg_if cfg_if ();
  adcms_host adcms_host_inst (.clk_i(clk_i), .rst_i(rst_i), .cfg(cfg_if),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .busy_o(busy_o));
  adcms_device adcms_device_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cfg(cfg_if), .powered_down_o(pd_o), .single_mode_o(single_o),
    .clk_div_code_o(div_o), .sample_tick_o(tick_o), .resync_o(resync_o),
    .route_first_o(first_o), .route_second_o(second_o),
    .bit_clk_phase_o(phase_o), .cm_buffer_drive_o(cm_o),
    .cfg_write_o(cfg_write_o));
  adcms_cfg_props adcms_cfg_props_inst (.clk_i(clk_i), .rst_i(rst_i),
    .sclk(cfg_if.sclk), .cs_n(cfg_if.cs_n), .sdata(cfg_if.sdata),
    .active_low_reset_pin_n(cfg_if.active_low_reset_pin_n),
    .power_down_pin(cfg_if.power_down_pin));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one-cycle pulses are counted so they can be judged later
  always @(posedge clk_i) begin
    if (resync_o === 1'b1) resyncs++;
    if (cfg_write_o === 1'b1) cfg_writes++;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", e, rdata_o);
  endtask

  // waits out the frames and the device's sync stages
  task automatic settle();
    repeat (2000) begin
      @(posedge clk_i);
      #1;
      if (busy_o === 1'b0) break;
    end
    chk("busy", 32'h0, 32'(busy_o));
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  task automatic tx(input logic [7:0] a, input logic [15:0] d);
    int n0;
    n0 = cfg_writes;
    wr(adcms_pkg::HADDR_TX, {8'h00, a, d});
    settle();
    chk("cfg_write", 32'(n0 + 1), 32'(cfg_writes));
  endtask

  task automatic pins(input logic [1:0] v);
    wr(adcms_pkg::HADDR_PINS, {30'h0, v});
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  task automatic ticks(input int e);
    int n;
    n = 0;
    repeat (40) begin
      @(posedge clk_i);
      #1;
      if (tick_o === 1'b1) n++;
    end
    chk("ticks", 32'(e), 32'(n));
  endtask

  task automatic t_defaults();
    chk("pd", 32'h0, 32'(pd_o));
    chk("single", 32'h1, 32'(single_o));
    chk("div", 32'h0, 32'(div_o));
    chk("phase", 32'(adcms_pkg::PHASE_RST), 32'(phase_o));
    chk("cm", 32'(adcms_pkg::CMBUF_RST), 32'(cm_o));
  endtask

  task automatic t_dual();
    tx(adcms_pkg::ADDR_POWER, adcms_pkg::POWER_DOWN_CMD);
    chk("pd", 32'h1, 32'(pd_o));
    tx(adcms_pkg::ADDR_PHASE, 16'h00a5);
    chk("phase", 32'h00a5, 32'(phase_o));
    tx(adcms_pkg::ADDR_MODE, adcms_pkg::MODE_DUAL_DIV2);
    chk("single", 32'h1, 32'(single_o));
    tx(adcms_pkg::ADDR_POWER, adcms_pkg::POWER_UP_CMD);
    chk("pd", 32'h0, 32'(pd_o));
    chk("resyncs", 32'h1, 32'(resyncs));
    chk("single", 32'h0, 32'(single_o));
    chk("div", 32'h1, 32'(div_o));
    ticks(20);
    tx(adcms_pkg::ADDR_XSEL_A, adcms_pkg::XSEL_DUAL_A);
    tx(adcms_pkg::ADDR_XSEL_B, adcms_pkg::XSEL_DUAL_B);
    chk("first", 32'(adcms_pkg::SRC_IN1), 32'(first_o));
    chk("second", 32'(adcms_pkg::SRC_IN2), 32'(second_o));
  endtask

  task automatic t_single();
    pins(2'b10);
    chk("pd", 32'h1, 32'(pd_o));
    tx(adcms_pkg::ADDR_MODE, adcms_pkg::MODE_SINGLE_DIV1);
    pins(2'b00);
    chk("pd", 32'h0, 32'(pd_o));
    chk("resyncs", 32'h2, 32'(resyncs));
    chk("single", 32'h1, 32'(single_o));
    chk("div", 32'h0, 32'(div_o));
    ticks(40);
    tx(adcms_pkg::ADDR_XSEL_A, adcms_pkg::XSEL_IN2_SINGLE);
    chk("first", 32'(adcms_pkg::SRC_IN2), 32'(first_o));
    tx(adcms_pkg::ADDR_XSEL_B, adcms_pkg::XSEL_IN2_SINGLE);
    chk("second", 32'(adcms_pkg::SRC_NONE), 32'(second_o));
    tx(adcms_pkg::ADDR_XSEL_A, adcms_pkg::XSEL_IN1);
    chk("first", 32'(adcms_pkg::SRC_IN1), 32'(first_o));
  endtask

  task automatic t_cm();
    tx(adcms_pkg::ADDR_CMBUF, 16'h0000);
    chk("cm", 32'h0, 32'(cm_o));
    tx(adcms_pkg::ADDR_CMBUF, 16'h0003);
    chk("cm", 32'h3, 32'(cm_o));
  endtask

  task automatic t_resets();
    // second request lands while busy and must be dropped
    wr(adcms_pkg::HADDR_TX, {8'h00, adcms_pkg::ADDR_PHASE, 16'h1111});
    tx(adcms_pkg::ADDR_PHASE, 16'h2222);
    chk("phase", 32'h1111, 32'(phase_o));
    tx(adcms_pkg::ADDR_SOFT_RESET, adcms_pkg::SOFT_RESET_CMD);
    chk("phase", 32'h0, 32'(phase_o));
    chk("cm", 32'(adcms_pkg::CMBUF_RST), 32'(cm_o));
    tx(adcms_pkg::ADDR_PHASE, 16'h00a5);
    pins(2'b01);
    pins(2'b00);
    chk("phase", 32'h0, 32'(phase_o));
    rd(4'hf, 32'h0);
  endtask

  // phase 0x33, dual mode, no soft reset: full setup from the host
  task automatic t_seq();
    wr(adcms_pkg::HADDR_SEQ, 32'h00330008);
    settle();
    chk("pd", 32'h0, 32'(pd_o));
    chk("resyncs", 32'h3, 32'(resyncs));
    chk("single", 32'h0, 32'(single_o));
    chk("div", 32'h1, 32'(div_o));
    chk("phase", 32'h00000033, 32'(phase_o));
    chk("first", 32'(adcms_pkg::SRC_IN1), 32'(first_o));
    chk("second", 32'(adcms_pkg::SRC_IN2), 32'(second_o));
    rd(adcms_pkg::HADDR_STATUS, 32'h00000070);
    rd(adcms_pkg::HADDR_SEQ, 32'h00330008);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    t_defaults();
    t_dual();
    t_single();
    t_cm();
    t_resets();
    t_seq();
    conclude();
  end
endmodule
`default_nettype wire
